/* logic/pcbcs_regs.vh */
`ifndef PCBCS_REGS_VH
`define PCBCS_REGS_VH

// Configuration dword offsets
`define PCBCS_OFF_STATUS_COMMAND 8'h04
`define PCBCS_OFF_CLASS_REVISION 8'h08

// Status/command field positions
`define PCBCS_BIT_PAR_DETECTED 31
`define PCBCS_BIT_FAST_B2B 23
`define PCBCS_BIT_66MHZ 21
`define PCBCS_BIT_PAR_RESPONSE 6
`define PCBCS_BIT_MEM_ENABLE 1
`define PCBCS_BIT_IO_ENABLE 0
`define PCBCS_DEVSEL_HI 26
`define PCBCS_DEVSEL_LO 25
`define PCBCS_DEVSEL_MEDIUM 2'h1

// Class code fields
`define PCBCS_BASE_CLASS 8'h06
`define PCBCS_SUB_CLASS 8'h80
`define PCBCS_PROG_IF 8'h00

// Reset values
`define PCBCS_RESET_CONTROL 1'h0

// Longest DEVSEL delay in clocks after the address phase
`define PCBCS_DEVSEL_MAX_CLK 3
`endif

/* logic/pcbcs_parity_flag.v */
`timescale 1ns/1ps
`include "pcbcs_regs.vh"

// Sticky detected-parity-error flag with write-one-to-clear
module pcbcs_parity_flag (
    input wire clk_sys, // 40 MHz clock
    input wire rstn, // Asynchronous reset, active low
    input wire set_pulse, // Parity error seen on a data phase
    input wire write_one_to_clear, // Config write with bit 31 high
    output reg flag_reg // Current flag value
);
    // Set beats clear so an error in the clearing cycle is not lost
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flag_reg <= 1'b0;
        end else if (set_pulse) begin
            flag_reg <= 1'b1;
        end else if (write_one_to_clear) begin
            flag_reg <= 1'b0;
        end
    end
endmodule // pcbcs_parity_flag

/* logic/pcbcs_config.v */
`timescale 1ns/1ps
`include "pcbcs_regs.vh"

// Configuration status/command and class/revision dwords of the bridge function
// Only the two dwords below are decoded; every other offset reads zero and drops writes.
// Reads and writes always finish the cycle after their strobe, so the host never waits.
// Limitation: the revision code is a parameter, so both functions must share one value.
module pcbcs_config #(
    parameter [7:0] REVISION_ID = 8'h5A, // Arbitrary value, shared with other function
    parameter [0:0] CAP_66MHZ = 1'b1 // One on later silicon revisions
) (
    input wire clk_sys, // 40 MHz PCI-side clock
    input wire rstn, // Asynchronous reset, active low
    input wire cfg_wr, // One-cycle configuration write strobe
    input wire cfg_rd, // One-cycle configuration read strobe
    input wire [7:0] cfg_addr, // Dword-aligned byte offset
    input wire [3:0] cfg_be, // Byte enables, active high
    input wire [31:0] cfg_wdata, // Write data
    output reg [31:0] cfg_rdata, // Read data, registered
    output reg cfg_ack, // Access done, one-cycle pulse
    input wire data_parity_err, // Pin-level parity error on a data phase
    input wire cycle_hits_self, // Data phase targets this function
    input wire mem_addr_match, // Memory cycle address hits our window
    input wire mem_cycle_start, // Address phase of a memory cycle
    output wire mem_space_enable, // Memory-space enable level
    output wire parity_response_enable, // Parity-error response enable
    output wire parity_err_report, // Take parity action, one-cycle pulse
    output reg devsel_claim // Claim memory cycle, registered pulse
);
    // Command bits that software can write
    reg par_resp_reg; // Command bit 6, parity-error response
    reg mem_en_reg; // Command bit 1, memory-space enable
    reg par_resp_next; // Next value of command bit 6
    reg mem_en_next; // Next value of command bit 1

    // Parity error synchroniser and edge detector
    reg perr_sync1_reg; // Synchroniser stage one
    reg perr_sync2_reg; // Synchroniser stage two
    reg perr_last_reg; // Edge detector history
    wire perr_pulse; // One pulse per error
    wire par_detected; // Sticky flag from leaf

    // Access decode
    wire sc_sel; // Status/command addressed
    wire cr_sel; // Class/revision addressed
    wire cmd_byte_wr; // Write reaching the command low byte
    wire status_clr_wr; // Write reaching the status top byte
    wire par_clear; // Write-one-to-clear of the parity flag

    // Fixed capability fields
    wire [1:0] devsel_field; // Medium decode speed
    wire fast_b2b_cap; // Fast back-to-back capable
    wire cap_66mhz; // Runs on the faster bus

    // Class code fields
    wire [7:0] base_class; // Bridge device
    wire [7:0] sub_class; // Other bridge
    wire [7:0] prog_if; // No special programming model
    wire [7:0] revision_code; // Shared silicon revision

    // Read images and registered outputs
    wire [31:0] fixed_status; // Read-only part of status/command
    wire [31:0] status_command; // Assembled dword
    wire [31:0] class_revision; // Assembled dword
    reg [31:0] rdata_next; // Read data about to be registered
    reg ack_next; // Acknowledge about to be registered
    reg devsel_next; // Claim about to be registered

    // Offset decode; only the two implemented dwords are recognised
    assign sc_sel = (cfg_addr == `PCBCS_OFF_STATUS_COMMAND);
    assign cr_sel = (cfg_addr == `PCBCS_OFF_CLASS_REVISION);

    // Byte lanes: the low byte carries the command bits, the top byte the flag
    assign cmd_byte_wr = cfg_wr & sc_sel & cfg_be[0];
    assign status_clr_wr = cfg_wr & sc_sel & cfg_be[3];
    assign par_clear = status_clr_wr & cfg_wdata[`PCBCS_BIT_PAR_DETECTED];

    // Enable levels leave straight from their registers
    assign mem_space_enable = mem_en_reg;
    assign parity_response_enable = par_resp_reg;

    // Error pin is asynchronous to us, so two stages before any edge logic
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            perr_sync1_reg <= 1'b0;
            perr_sync2_reg <= 1'b0;
            perr_last_reg <= 1'b0;
        end else begin
            perr_sync1_reg <= data_parity_err;
            perr_sync2_reg <= perr_sync1_reg;
            perr_last_reg <= perr_sync2_reg;
        end
    end

    // Rising edge only, so a long error level counts as one error
    assign perr_pulse = perr_sync2_reg & ~perr_last_reg;

    // Detection is always recorded; action only when enabled and targeted
    assign parity_err_report = perr_pulse & par_resp_reg & cycle_hits_self;

    // Sticky flag sits in its own leaf so set-over-clear priority lives in one place
    pcbcs_parity_flag u_parity_flag (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .set_pulse(perr_pulse),
        .write_one_to_clear(par_clear),
        .flag_reg(par_detected)
    );

    // Next command bits; a write without the low byte keeps the old values
    always @* begin
        par_resp_next = par_resp_reg;
        mem_en_next = mem_en_reg;
        if (cmd_byte_wr) begin
            par_resp_next = cfg_wdata[`PCBCS_BIT_PAR_RESPONSE];
            mem_en_next = cfg_wdata[`PCBCS_BIT_MEM_ENABLE];
        end
    end

    // Command bit registers; read-only bits have no storage so writes drop away
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            par_resp_reg <= `PCBCS_RESET_CONTROL;
            mem_en_reg <= `PCBCS_RESET_CONTROL;
        end else begin
            par_resp_reg <= par_resp_next;
            mem_en_reg <= mem_en_next;
        end
    end

    // Claim only while memory space is enabled
    always @* begin
        devsel_next = mem_cycle_start & mem_addr_match & mem_en_reg;
    end

    // Claim on the clock after the address phase, well inside three clocks
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            devsel_claim <= 1'b0;
        end else begin
            devsel_claim <= devsel_next;
        end
    end

    // Capability fields; the faster-bus bit follows the silicon revision
    assign devsel_field = `PCBCS_DEVSEL_MEDIUM;
    assign fast_b2b_cap = 1'b1;
    assign cap_66mhz = CAP_66MHZ;

    // Fixed part of status/command; live bit positions hold zero here
    assign fixed_status = {
        1'h0, // Flag position, live bit
        4'h0,
        devsel_field,
        1'h0,
        fast_b2b_cap,
        1'h0,
        cap_66mhz,
        5'h00,
        9'h000,
        1'h0, // Parity response position, live bit
        4'h0,
        1'h0, // Memory enable position, live bit
        1'h0
    };

    // One source per bit: live bits from storage, the rest from the fixed image
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < 32; bit_idx = bit_idx + 1) begin : g_status_bit
            if (bit_idx == `PCBCS_BIT_PAR_DETECTED) begin : g_flag
                assign status_command[bit_idx] = par_detected;
            end else if (bit_idx == `PCBCS_BIT_PAR_RESPONSE) begin : g_resp
                assign status_command[bit_idx] = par_resp_reg;
            end else if (bit_idx == `PCBCS_BIT_MEM_ENABLE) begin : g_mem
                assign status_command[bit_idx] = mem_en_reg;
            end else begin : g_fixed
                assign status_command[bit_idx] = fixed_status[bit_idx];
            end
        end
    endgenerate

    // Class/revision is wholly read-only; the revision is shared with the other function
    assign base_class = `PCBCS_BASE_CLASS;
    assign sub_class = `PCBCS_SUB_CLASS;
    assign prog_if = `PCBCS_PROG_IF;
    assign revision_code = REVISION_ID;
    assign class_revision = {base_class, sub_class, prog_if, revision_code};

    // Read mux; read data only moves on a read, so it holds between accesses
    always @* begin
        rdata_next = cfg_rdata;
        ack_next = cfg_wr | cfg_rd;
        if (cfg_rd) begin
            if (sc_sel) begin
                rdata_next = status_command;
            end else if (cr_sel) begin
                rdata_next = class_revision;
            end else begin
                rdata_next = 32'h00000000;
            end
        end
    end

    // Every access acknowledges next cycle; unmapped offsets read zero
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_ack <= 1'b0;
            cfg_rdata <= 32'h00000000;
        end else begin
            cfg_ack <= ack_next;
            cfg_rdata <= rdata_next;
        end
    end
endmodule // pcbcs_config

/* testbench/pcbcs_checker.sv */
`timescale 1ns/1ps
// Watches config access timing, fixed read fields and the side-band outputs
module pcbcs_checker (
    input wire clk_sys, rstn, cfg_wr, cfg_rd, cfg_ack, cycle_hits_self, // Control inputs
    input wire mem_addr_match, mem_cycle_start, mem_space_enable, // Memory side
    input wire parity_response_enable, parity_err_report, devsel_claim, // Outputs
    input wire [7:0] cfg_addr, // Offset
    input wire [3:0] cfg_be, // Byte enables
    input wire [31:0] cfg_wdata, cfg_rdata // Data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Enabled memory cycle in our window, and a command-byte write
    sequence s_claim;
        mem_cycle_start && mem_addr_match && mem_space_enable;
    endsequence
    sequence s_cmd_wr;
        cfg_wr && cfg_addr == 8'h04 && cfg_be[0];
    endsequence
    a_ack_follows: assert property ((cfg_wr || cfg_rd) |=> cfg_ack) else $error("ack missing");
    a_ack_cause: assert property (cfg_ack |-> $past(cfg_wr || cfg_rd)) else $error("stray ack");
    a_claim_soon: assert property (s_claim |=> devsel_claim) else $error("no claim");
    a_claim_cause: assert property (devsel_claim |->
        $past(mem_cycle_start && mem_addr_match && mem_space_enable)) else $error("bad claim");
    a_enable_load: assert property (s_cmd_wr |=> mem_space_enable == $past(cfg_wdata[1]) &&
        parity_response_enable == $past(cfg_wdata[6])) else $error("enable load");
    a_enable_hold: assert property (!(cfg_wr && cfg_be[0]) |=> $stable(mem_space_enable) &&
        $stable(parity_response_enable)) else $error("enable drift");
    a_par_gate: assert property (parity_err_report |-> parity_response_enable && cycle_hits_self)
        else $error("parity report ungated");
    a_class_read: assert property (cfg_rd && cfg_addr == 8'h08 |=>
        cfg_rdata[31:8] == 24'h068000) else $error("class code");
    a_status_fixed: assert property (cfg_rd && cfg_addr == 8'h04 |=>
        (cfg_rdata & 32'h7FFFFFBD) == 32'h02A00000) else $error("status fixed");
endmodule // pcbcs_checker

/* testbench/pcbcs_far_end.sv */
`timescale 1ns/1ps
// Host side parity signalling; error line is registered so it never moves on the edge
module pcbcs_far_end (
    input wire clk_sys, // Clock
    input wire err_go, // Bench asks for a bad data phase
    output reg data_parity_err = 1'b0 // Parity error line
);
    always @(posedge clk_sys) begin
        data_parity_err <= err_go;
    end
endmodule // pcbcs_far_end

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 0, rstn = 0, cfg_wr = 0, cfg_rd = 0, cyc = 0, mst = 0, mam = 0, err_go = 0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0, rd;
    wire [31:0] cfg_rdata;
    wire ack, mse, pre, per, claim, dpe;
    int err_count = 0, comparisons = 0, cycles = 0, per_count = 0;
    // Rows: offset, byte enables, write, write data, expected read
    logic [76:0] rows [6] = '{{8'h04, 4'hF, 1'b0, 32'h0, 32'h02A00000},
        {8'h08, 4'hF, 1'b0, 32'h0, 32'h0680005A}, {8'h04, 4'hF, 1'b1, 32'hFFFFFFFF, 32'h02A00042},
        {8'h04, 4'h0, 1'b1, 32'h0, 32'h02A00042}, {8'h08, 4'hF, 1'b1, 32'hFFFFFFFF, 32'h0680005A},
        {8'h0C, 4'hF, 1'b0, 32'h0, 32'h0}};
    pcbcs_config u_dut (.clk_sys(clk_sys), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(ack), .data_parity_err(dpe), .cycle_hits_self(cyc), .mem_addr_match(mam),
        .mem_cycle_start(mst), .mem_space_enable(mse), .parity_response_enable(pre),
        .parity_err_report(per), .devsel_claim(claim));
    pcbcs_far_end u_host (.clk_sys(clk_sys), .err_go(err_go), .data_parity_err(dpe));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task complete_run;
        $display("err_count=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    // One config access; ack and data land the cycle after the strobe
    task acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk_sys);
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} <= {w, !w, a, b, d};
        @(posedge clk_sys);
        {cfg_wr, cfg_rd} <= 2'b00;
        #1 rd = cfg_rdata;
        chk({31'h0, ack}, 32'h1);
    endtask
    // Memory cycle in our window; claim expected the next cycle only when enabled
    task mem_try(input logic [31:0] exp);
        @(posedge clk_sys);
        {mst, mam} <= 2'b11;
        @(posedge clk_sys);
        mst <= 0;
        #1 chk({31'h0, claim}, exp);
    endtask
    // Count parity-action pulses so the report output is checked too
    always @(posedge clk_sys) begin
        if (per === 1'b1) per_count++;
    end
    // Hang guard, far above the 60 cycles the run needs
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            complete_run;
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1;
        foreach (rows[i]) begin
            if (rows[i][64]) acc(1, rows[i][76:69], rows[i][68:65], rows[i][63:32]);
            acc(0, rows[i][76:69], 4'hF, 32'h0);
            chk(rd, rows[i][31:0]);
        end
        @(posedge clk_sys);
        cyc <= 1;
        err_go <= 1;
        repeat (2) @(posedge clk_sys);
        err_go <= 0;
        repeat (3) @(posedge clk_sys);
        acc(0, 8'h04, 4'hF, 32'h0);
        chk(rd, 32'h82A00042);
        chk(per_count, 32'h1);
        acc(1, 8'h04, 4'hF, 32'h00000042);
        acc(0, 8'h04, 4'hF, 32'h0);
        chk(rd, 32'h82A00042);
        acc(1, 8'h04, 4'hF, 32'h80000042);
        acc(0, 8'h04, 4'hF, 32'h0);
        chk(rd, 32'h02A00042);
        mem_try(32'h1);
        acc(1, 8'h04, 4'hF, 32'h0);
        mem_try(32'h0);
        // Error with response off: flag still sets, no action pulse
        @(posedge clk_sys);
        err_go <= 1;
        repeat (2) @(posedge clk_sys);
        err_go <= 0;
        repeat (3) @(posedge clk_sys);
        acc(0, 8'h04, 4'hF, 32'h0);
        chk(rd, 32'h82A00000);
        chk(per_count, 32'h1);
        // Mid-run reset drops the enables and the flag
        acc(1, 8'h04, 4'h1, 32'h00000042);
        chk({30'h0, mse, pre}, 32'h3);
        @(posedge clk_sys);
        rstn <= 0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1;
        acc(0, 8'h04, 4'hF, 32'h0);
        chk(rd, 32'h02A00000);
        chk({30'h0, mse, pre}, 32'h0);
        complete_run;
    end
endmodule // tb_top
bind pcbcs_config pcbcs_checker u_chk (.*);
